// ===== iadthc_consts.svh
/*
  Named constants of the image acquisition DMA core: sizes, register
  offsets, reset values, descriptor defaults and interrupt bit positions.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef IADTHC_CONSTS_SVH
`define IADTHC_CONSTS_SVH

// Group count, group index width and host FIFO geometry
`define IADTHC_NUM_GROUPS 16
`define IADTHC_GRP_W 4
`define IADTHC_WORD_W 64
`define IADTHC_FIFO_DEPTH 16
`define IADTHC_FIFO_AW 4

// Register bus geometry and byte offsets
`define IADTHC_ADDR_W 8
`define IADTHC_DATA_W 32
`define IADTHC_OFF_CTRL 8'h00
`define IADTHC_OFF_LINK_MODE 8'h04
`define IADTHC_OFF_GROUP_ENABLE 8'h08
`define IADTHC_OFF_OVERFLOW 8'h0C
`define IADTHC_OFF_NUM_GROUPS 8'h10
`define IADTHC_OFF_SER_TX 8'h14
`define IADTHC_OFF_SER_RX 8'h18
`define IADTHC_OFF_IRQ_STATUS 8'h1C
`define IADTHC_OFF_IRQ_CLEAR 8'h20
`define IADTHC_OFF_IRQ_ENABLE 8'h24
// Descriptor window: 8'h40 + 4 * group, selected by address bits [7:6]
`define IADTHC_DESC_SEL 2'h1

// Control bit, link mode reset value and largest legal link mode
`define IADTHC_CTRL_RUN 0
`define IADTHC_RST_LINK_MODE 8'h00
`define IADTHC_LINK_MODE_MAX 8'h02

// Per-group descriptor defaults: channels, frame format, sample bytes
`define IADTHC_DEF_NCH 16'h0001
`define IADTHC_DEF_FMT 8'h00
`define IADTHC_DEF_BYTES 8'h01

// Valid sample sizes in bytes
`define IADTHC_SZ_1 8'h01
`define IADTHC_SZ_2 8'h02
`define IADTHC_SZ_4 8'h04
`define IADTHC_SZ_8 8'h08

// Interrupt status bits
`define IADTHC_IRQ_W 3
`define IADTHC_IRQ_FRAME 0
`define IADTHC_IRQ_OVF 1
`define IADTHC_IRQ_RX 2

`endif

// ===== iadthc_pkg.sv
/*
  Types shared by the image acquisition DMA core files.
  Assumes the constants header is reachable by its bare name.
*/
`default_nettype none
`include "iadthc_consts.svh"
package iadthc_pkg;
  // One host FIFO word
  typedef logic [`IADTHC_WORD_W-1:0] iadthc_word_t;
  // Camera link mode
  typedef enum logic [7:0] {
    IADTHC_LINK_BASE = 8'h00,
    IADTHC_LINK_MEDIUM = 8'h01,
    IADTHC_LINK_FULL = 8'h02
  } iadthc_link_mode_e;
  // Frame format code reported per group
  typedef enum logic [7:0] {
    IADTHC_FMT_A = 8'h00,
    IADTHC_FMT_B = 8'h01
  } iadthc_frame_fmt_e;
  // Per-group capture gate state, one-hot
  typedef enum logic [1:0] {
    IADTHC_GATE_IDLE = 2'b01,
    IADTHC_GATE_CAPTURE = 2'b10
  } iadthc_gate_state_e;
endpackage
`default_nettype wire

// ===== iadthc_gate.sv
/*
  Per-group capture gate: applies the group enable at frame starts and
  keeps the sticky overflow flag of the group.
  Assumes frame_start is a one-cycle pulse and all inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iadthc_consts.svh"
module iadthc_gate (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic frame_start,
  input wire logic enable_req,
  input wire logic restart,
  input wire logic ovf_event,
  output logic capture,
  output logic ovf_flag
);
  import iadthc_pkg::*;

  iadthc_gate_state_e state; // Capturing or not for the running frame
  iadthc_gate_state_e next_state;
  logic next_ovf;

  // Enable is looked at only on the frame start pulse
  always_comb begin
    next_state = state;
    case (state)
      IADTHC_GATE_IDLE: begin
        if (frame_start && enable_req) next_state = IADTHC_GATE_CAPTURE;
      end
      IADTHC_GATE_CAPTURE: begin
        if (frame_start && !enable_req) next_state = IADTHC_GATE_IDLE;
      end
      default: begin
        next_state = IADTHC_GATE_IDLE;
      end
    endcase
  end

  // Samples in the edge cycle already follow the new enable
  assign capture = frame_start ? enable_req :
                   (state == IADTHC_GATE_CAPTURE);

  // New overflow beats a restart in the same cycle
  assign next_ovf = ovf_event | (ovf_flag & ~restart);

  // State and flag registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= IADTHC_GATE_IDLE;
      ovf_flag <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      ovf_flag <= next_ovf;
    end
  end
endmodule
`default_nettype wire

// ===== iadthc_packer.sv
/*
  Per-group packer and host FIFO: packs samples of the group's size into
  64-bit words, low byte first, and queues them toward one DMA channel.
  Assumes the sample sits in the low bytes of in_sample.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iadthc_consts.svh"
module iadthc_packer (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic frame_start,
  input wire logic capture,
  input wire logic in_valid,
  input wire iadthc_pkg::iadthc_word_t in_sample,
  input wire logic [7:0] sample_bytes,
  output iadthc_pkg::iadthc_word_t out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic overflow_event
);
  import iadthc_pkg::*;

  iadthc_word_t acc; // Word under assembly
  logic [2:0] fill; // Bytes already in acc
  iadthc_word_t mem [`IADTHC_FIFO_DEPTH]; // Host FIFO storage
  logic [`IADTHC_FIFO_AW:0] wptr; // Extra bit tells full from empty
  logic [`IADTHC_FIFO_AW:0] rptr;

  // Size decode; size 0 or any other code drops the sample
  wire size_ok = (sample_bytes == `IADTHC_SZ_1) ||
    (sample_bytes == `IADTHC_SZ_2) || (sample_bytes == `IADTHC_SZ_4) ||
    (sample_bytes == `IADTHC_SZ_8);
  wire [3:0] step = size_ok ? sample_bytes[3:0] : 4'h0;
  // Three bits wrap size eight to a zero shift, keeping the whole word
  wire [`IADTHC_WORD_W-1:0] mask = {`IADTHC_WORD_W{1'b1}} >>
    {~(step[2:0] - 3'h1), 3'b000};
  wire take = in_valid & capture & size_ok;
  // A sample beside the frame start must not join the stale partial word
  wire [2:0] cur_fill = frame_start ? 3'h0 : fill;
  wire [`IADTHC_WORD_W-1:0] cur_acc = frame_start ? '0 : acc;
  wire [3:0] sum = {1'b0, cur_fill} + step;
  wire word_done = take & sum[3];
  wire [5:0] shamt = {cur_fill, 3'b000};
  wire [`IADTHC_WORD_W-1:0] merged = cur_acc | ((in_sample & mask) << shamt);
  wire empty = (wptr == rptr);
  wire full = (wptr[`IADTHC_FIFO_AW] != rptr[`IADTHC_FIFO_AW]) &&
    (wptr[`IADTHC_FIFO_AW-1:0] == rptr[`IADTHC_FIFO_AW-1:0]);
  wire push = word_done & ~full;
  wire pop = out_valid & out_ready;

  assign out_valid = ~empty;
  assign out_data = mem[rptr[`IADTHC_FIFO_AW-1:0]];
  // A finished word meeting a full FIFO is lost and reported
  assign overflow_event = word_done & full;

  // Assembly: a frame start drops any partial word to realign
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc <= '0;
      fill <= 3'h0;
    end else if (ce) begin
      if (frame_start && !take) begin
        acc <= '0;
        fill <= 3'h0;
      end else if (take) begin
        acc <= word_done ? '0 : merged;
        fill <= sum[2:0];
      end
    end
  end

  // FIFO pointers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end

  // FIFO storage needs no reset
  always_ff @(posedge clock) begin
    if (ce && push) mem[wptr[`IADTHC_FIFO_AW-1:0]] <= merged;
  end
endmodule
`default_nettype wire

// ===== iadthc_core.sv
/*
  Image acquisition DMA core top: register port, frame start detection,
  per-group capture gates, packers with host FIFOs, camera link mode,
  camera serial byte path and the interrupt.
  Assumes a single clock, camera signals synchronous to it, and a serial
  transmitter and receiver outside this logic that exchange bytes.
*/
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "iadthc_consts.svh"
module iadthc_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [`IADTHC_ADDR_W-1:0] reg_addr,
  input wire logic [`IADTHC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`IADTHC_DATA_W-1:0] reg_rdata,
  // Camera sample stream, already sorted into groups
  input wire logic cam_frame_valid,
  input wire logic cam_sample_valid,
  input wire iadthc_pkg::iadthc_word_t cam_sample,
  input wire logic [`IADTHC_GRP_W-1:0] cam_sample_group,
  output iadthc_pkg::iadthc_link_mode_e cam_link_mode,
  // Camera serial byte path toward the adapter transceiver
  output logic [7:0] ser_tx_data,
  output logic ser_tx_valid,
  input wire logic ser_tx_ready,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_valid,
  // Host FIFOs, one per group
  output iadthc_pkg::iadthc_word_t
    group_host_fifo_data [`IADTHC_NUM_GROUPS],
  output logic [`IADTHC_NUM_GROUPS-1:0] group_host_fifo_valid,
  input wire logic [`IADTHC_NUM_GROUPS-1:0] group_host_fifo_ready,
  // Interrupt, level
  output logic irq
);
  import iadthc_pkg::*;

  // Control state
  logic run; // Acquisition running
  logic run_q; // Previous run, for restart edge
  logic fv_q; // Previous frame valid, for frame edge
  iadthc_link_mode_e link_mode; // Selected camera link mode
  logic [`IADTHC_NUM_GROUPS-1:0] group_capture_enable; // Requested enables
  logic [`IADTHC_NUM_GROUPS-1:0] group_overflow_flags; // Sticky per group
  logic [`IADTHC_NUM_GROUPS-1:0] group_capture; // Applied enables
  logic [`IADTHC_NUM_GROUPS-1:0] group_ovf_event; // Lost-word pulses
  // Serial byte holding
  logic [7:0] tx_byte; // Byte waiting for the transmitter
  logic tx_pending; // Transmitter has not taken tx_byte yet
  logic [7:0] rx_byte; // Last byte from the camera
  logic rx_full; // rx_byte not yet read
  // Interrupt registers
  logic [`IADTHC_IRQ_W-1:0] irq_status;
  logic [`IADTHC_IRQ_W-1:0] irq_enable;
  logic [`IADTHC_IRQ_W-1:0] irq_set;
  logic [`IADTHC_IRQ_W-1:0] next_irq_status;
  logic [`IADTHC_DATA_W-1:0] next_rdata;

  // Group descriptors, fixed at build time; one entry per group
  logic [15:0] group_channel_counts [`IADTHC_NUM_GROUPS];
  iadthc_frame_fmt_e group_frame_format [`IADTHC_NUM_GROUPS];
  logic [7:0] group_sample_bytes [`IADTHC_NUM_GROUPS];

  // Write decode
  wire wr_ctrl = reg_wr && (reg_addr == `IADTHC_OFF_CTRL);
  wire wr_mode = reg_wr && (reg_addr == `IADTHC_OFF_LINK_MODE);
  wire wr_en = reg_wr && (reg_addr == `IADTHC_OFF_GROUP_ENABLE);
  wire wr_tx = reg_wr && (reg_addr == `IADTHC_OFF_SER_TX);
  wire wr_clr = reg_wr && (reg_addr == `IADTHC_OFF_IRQ_CLEAR);
  wire wr_ien = reg_wr && (reg_addr == `IADTHC_OFF_IRQ_ENABLE);
  // Reading the receive register consumes the byte
  wire rd_rx = reg_rd && (reg_addr == `IADTHC_OFF_SER_RX);

  // Link mode codes above full are refused, keeping the old mode
  wire mode_ok = (reg_wdata[7:0] <= `IADTHC_LINK_MODE_MAX);

  // Frame start is the rising edge of frame valid
  wire frame_start = cam_frame_valid & ~fv_q;
  // Restart is the rising edge of run; it clears overflow flags
  wire restart = run & ~run_q;

  // Descriptor window index
  wire desc_hit = (reg_addr[7:6] == `IADTHC_DESC_SEL);
  wire [`IADTHC_GRP_W-1:0] desc_idx = reg_addr[5:2];

  // Serial handshakes
  wire tx_taken = tx_pending & ser_tx_ready;
  wire tx_load = wr_tx & ~tx_pending; // A write while busy is ignored

  // Events feeding the sticky interrupt status
  assign irq_set[`IADTHC_IRQ_FRAME] = frame_start;
  assign irq_set[`IADTHC_IRQ_OVF] = |group_ovf_event;
  assign irq_set[`IADTHC_IRQ_RX] = ser_rx_valid;
  // Set beats a clear written in the same cycle
  assign next_irq_status = (irq_status &
    ~(wr_clr ? reg_wdata[`IADTHC_IRQ_W-1:0] : '0)) | irq_set;
  assign irq = |(irq_status & irq_enable);

  // Outputs toward the camera side
  assign cam_link_mode = link_mode;
  assign ser_tx_data = tx_byte;
  assign ser_tx_valid = tx_pending;

  // One gate and one packer per group; sixteen groups in all
  genvar g;
  generate
    for (g = 0; g < `IADTHC_NUM_GROUPS; g++) begin : gen_group
      // Descriptors: one size per group so channels cannot mix widths
      assign group_channel_counts[g] = `IADTHC_DEF_NCH;
      assign group_frame_format[g] = iadthc_frame_fmt_e'(`IADTHC_DEF_FMT);
      assign group_sample_bytes[g] = `IADTHC_DEF_BYTES;

      iadthc_gate u_gate (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .frame_start(frame_start),
        .enable_req(group_capture_enable[g] & run),
        .restart(restart),
        .ovf_event(group_ovf_event[g]),
        .capture(group_capture[g]),
        .ovf_flag(group_overflow_flags[g])
      );

      iadthc_packer u_packer (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .frame_start(frame_start),
        .capture(group_capture[g] & cam_frame_valid),
        .in_valid(cam_sample_valid &&
                  (cam_sample_group == `IADTHC_GRP_W'(g))),
        .in_sample(cam_sample),
        .sample_bytes(group_sample_bytes[g]),
        .out_data(group_host_fifo_data[g]),
        .out_valid(group_host_fifo_valid[g]),
        .out_ready(group_host_fifo_ready[g]),
        .overflow_event(group_ovf_event[g])
      );
    end
  endgenerate

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (desc_hit) begin
      // Channels low, format next, sample bytes on top
      next_rdata = {group_sample_bytes[desc_idx],
                    8'(group_frame_format[desc_idx]),
                    group_channel_counts[desc_idx]};
    end else begin
      case (reg_addr)
        `IADTHC_OFF_CTRL: begin
          next_rdata[`IADTHC_CTRL_RUN] = run;
        end
        `IADTHC_OFF_LINK_MODE: begin
          next_rdata[7:0] = link_mode;
        end
        `IADTHC_OFF_GROUP_ENABLE: begin
          next_rdata[`IADTHC_NUM_GROUPS-1:0] = group_capture_enable;
        end
        `IADTHC_OFF_OVERFLOW: begin
          next_rdata[`IADTHC_NUM_GROUPS-1:0] = group_overflow_flags;
        end
        `IADTHC_OFF_NUM_GROUPS: begin
          next_rdata = `IADTHC_DATA_W'(`IADTHC_NUM_GROUPS);
        end
        `IADTHC_OFF_SER_TX: begin
          next_rdata[0] = tx_pending;
        end
        `IADTHC_OFF_SER_RX: begin
          next_rdata[8:0] = {rx_full, rx_byte};
        end
        `IADTHC_OFF_IRQ_STATUS: begin
          next_rdata[`IADTHC_IRQ_W-1:0] = irq_status;
        end
        `IADTHC_OFF_IRQ_ENABLE: begin
          next_rdata[`IADTHC_IRQ_W-1:0] = irq_enable;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  // Software controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run <= 1'b0;
      link_mode <= iadthc_link_mode_e'(`IADTHC_RST_LINK_MODE);
      group_capture_enable <= '0;
      irq_enable <= '0;
    end else if (ce) begin
      if (wr_ctrl) run <= reg_wdata[`IADTHC_CTRL_RUN];
      if (wr_mode && mode_ok) begin
        link_mode <= iadthc_link_mode_e'(reg_wdata[7:0]);
      end
      // Requested only; the gates apply it at the next frame start
      if (wr_en) begin
        group_capture_enable <= reg_wdata[`IADTHC_NUM_GROUPS-1:0];
      end
      if (wr_ien) irq_enable <= reg_wdata[`IADTHC_IRQ_W-1:0];
    end
  end

  // Edge history for frame start and restart
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fv_q <= 1'b0;
      run_q <= 1'b0;
    end else if (ce) begin
      fv_q <= cam_frame_valid;
      run_q <= run;
    end
  end

  // Serial transmit byte: held until the transmitter takes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_byte <= 8'h00;
      tx_pending <= 1'b0;
    end else if (ce) begin
      if (tx_load) begin
        tx_byte <= reg_wdata[7:0];
        tx_pending <= 1'b1;
      end else if (tx_taken) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // Serial receive byte: a new byte overwrites; arrival beats the read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_byte <= 8'h00;
      rx_full <= 1'b0;
    end else if (ce) begin
      if (ser_rx_valid) begin
        rx_byte <= ser_rx_data;
        rx_full <= 1'b1;
      end else if (rd_rx) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Sticky interrupt status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (ce) begin
      irq_status <= next_irq_status;
    end
  end
endmodule
`default_nettype wire

// ===== iadthc_props.sv
/*
  Checker of port relations of the image acquisition DMA core.
  Assumes it is bound to iadthc_core and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iadthc_consts.svh"
module iadthc_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`IADTHC_ADDR_W-1:0] reg_addr,
  input wire logic [`IADTHC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`IADTHC_DATA_W-1:0] reg_rdata,
  input wire iadthc_pkg::iadthc_link_mode_e cam_link_mode,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  input wire logic ser_tx_ready,
  input wire logic [`IADTHC_NUM_GROUPS-1:0] group_host_fifo_valid,
  input wire logic [`IADTHC_NUM_GROUPS-1:0] group_host_fifo_ready
);
  import iadthc_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Accepted strobes; ce low freezes everything
  wire logic rd_ok = ce && reg_rd;
  wire logic wr_ok = ce && reg_wr;
  wire logic lm_wr = wr_ok && reg_addr == `IADTHC_OFF_LINK_MODE;
  // Low byte of a write, a plain signal for $past
  wire logic [7:0] wr_byte = reg_wdata[7:0];
  // FIFO heads that were shown but not taken
  wire logic [15:0] held = group_host_fifo_valid & ~group_host_fifo_ready;

  AST_RD_IDLE: assert property (ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_NUM_GROUPS: assert property (
    rd_ok && reg_addr == `IADTHC_OFF_NUM_GROUPS |=> reg_rdata == 32'h0000_0010)
    else $error("group count read wrong");
  AST_DESC: assert property (
    rd_ok && reg_addr[7:6] == `IADTHC_DESC_SEL |=> reg_rdata == 32'h0100_0001)
    else $error("group descriptor read wrong");
  AST_OVF_WIDTH: assert property (
    rd_ok && reg_addr == `IADTHC_OFF_OVERFLOW |=> reg_rdata[31:16] == 16'h0000)
    else $error("overflow flags wider than sixteen bits");
  AST_LINK_LEGAL: assert property (cam_link_mode <= IADTHC_LINK_FULL)
    else $error("link mode out of range");
  AST_LINK_WR: assert property (
    lm_wr && reg_wdata <= 32'h0000_0002 |=> cam_link_mode == $past(wr_byte))
    else $error("legal link mode write not applied");
  AST_LINK_HOLD: assert property (!lm_wr |=> $stable(cam_link_mode))
    else $error("link mode changed without a write");
  AST_TX_LOAD: assert property (
    wr_ok && reg_addr == `IADTHC_OFF_SER_TX && !ser_tx_valid
    |=> ser_tx_valid && ser_tx_data == $past(wr_byte))
    else $error("serial byte not launched");
  AST_TX_HOLD: assert property (
    ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
    else $error("serial byte dropped before taken");
  AST_TX_DONE: assert property (
    ce && ser_tx_valid && ser_tx_ready |=> !ser_tx_valid)
    else $error("serial byte not retired");
  AST_FIFO_HOLD: assert property (
    1'b1 |=> ($past(held) & ~group_host_fifo_valid) == 16'h0000)
    else $error("host word vanished before pop");
endmodule
bind iadthc_core iadthc_props u_props (.clock(clock), .rst(rst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_link_mode(cam_link_mode),
  .ser_tx_data(ser_tx_data), .ser_tx_valid(ser_tx_valid),
  .ser_tx_ready(ser_tx_ready), .group_host_fifo_valid(group_host_fifo_valid),
  .group_host_fifo_ready(group_host_fifo_ready));
`default_nettype wire

// ===== iadthc_cam_model.sv
/*
  Camera side model: frames of byte samples and the serial byte path.
  Assumes the bench calls its tasks and that all lines share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module iadthc_cam_model (
  input wire logic clock,
  input wire logic slow,
  output logic cam_frame_valid,
  output logic cam_sample_valid,
  output iadthc_pkg::iadthc_word_t cam_sample,
  output logic [3:0] cam_sample_group,
  output logic ser_tx_ready,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_valid
);
  import iadthc_pkg::*;
  logic [2:0] cnt = 3'h0; // Paces the slow transmitter
  // Quiet lines at time zero
  initial begin
    cam_frame_valid = 1'b0;
    cam_sample_valid = 1'b0;
    cam_sample = 64'h0000_0000_0000_0000;
    cam_sample_group = 4'h0;
    ser_rx_data = 8'h00;
    ser_rx_valid = 1'b0;
    ser_tx_ready = 1'b0;
  end
  // Transmitter takes a byte every cycle, or one in eight when slow
  always @(posedge clock) begin
    cnt <= cnt + 3'h1;
    ser_tx_ready <= !slow || cnt == 3'h7;
  end
  // Frame: frame valid rises, then n samples back to back; upper bytes junk
  task automatic frame(input logic [3:0] g, input int n, input logic [7:0] b);
    @(posedge clock);
    cam_frame_valid <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clock);
      cam_sample_valid <= 1'b1;
      cam_sample <= {56'hFF_FFFF_FFFF_FFFF, 8'(b + k)};
      cam_sample_group <= g;
    end
    @(posedge clock);
    cam_sample_valid <= 1'b0;
    cam_sample <= ~cam_sample; // Released lines show no stale value
    cam_sample_group <= ~g;
    cam_frame_valid <= 1'b0;
  endtask
  // One received status byte, one-cycle pulse
  task automatic rx(input logic [7:0] b);
    @(posedge clock);
    ser_rx_valid <= 1'b1;
    ser_rx_data <= b;
    @(posedge clock);
    ser_rx_valid <= 1'b0;
    ser_rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

// ===== iadthc_core_tb.sv
/*
  Self-checking bench of the image acquisition DMA core.
  Assumes the core, its checker and the camera model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iadthc_consts.svh"
module iadthc_core_tb;
  import iadthc_pkg::*;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1; // ce drops in one scenario
  logic [7:0] reg_addr = 8'h00, b;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, slow = 1'b0, irq;
  logic fv, sv, txv, txr, rxv;
  iadthc_word_t smp;
  logic [3:0] sgrp;
  iadthc_link_mode_e lmode;
  logic [7:0] txd, rxd;
  iadthc_word_t hdata [16];
  logic [15:0] hvalid, hready = 16'h0000, hmask = 16'hFFFF;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [31:0] rdq_e[$], rdq_m[$]; // Expected read data and mask
  iadthc_word_t fq[16][$]; // Expected host words per group
  logic [7:0] txq[$];

  initial begin
    forever #2 clock = ~clock;
  end
  iadthc_core uut (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cam_frame_valid(fv), .cam_sample_valid(sv),
    .cam_sample(smp), .cam_sample_group(sgrp), .cam_link_mode(lmode),
    .ser_tx_data(txd), .ser_tx_valid(txv), .ser_tx_ready(txr),
    .ser_rx_data(rxd), .ser_rx_valid(rxv), .group_host_fifo_data(hdata),
    .group_host_fifo_valid(hvalid), .group_host_fifo_ready(hready),
    .irq(irq));
  iadthc_cam_model cam (.clock(clock), .slow(slow), .cam_frame_valid(fv),
    .cam_sample_valid(sv), .cam_sample(smp), .cam_sample_group(sgrp),
    .ser_tx_ready(txr), .ser_rx_data(rxd), .ser_rx_valid(rxv));

  task automatic chk(input string nm, input logic [63:0] s,
                     input logic [63:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One-cycle write; released data is inverted so nothing stale is read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-cycle read; the monitor compares the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rdq_e.push_back(e);
    rdq_m.push_back(m);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  // Eight one-byte samples form one word, first sample in the low byte
  function automatic iadthc_word_t wordof(input logic [7:0] v);
    iadthc_word_t w;
    for (int k = 0; k < 8; k++) w[8*k +: 8] = 8'(v + k);
    return w;
  endfunction
  // Frame of nw words for group g, of which the first keep are expected
  task automatic send(input int g, input int nw, input int keep,
                      input logic [7:0] v);
    for (int j = 0; j < keep; j++) fq[g].push_back(wordof(8'(v + 8 * j)));
    cam.frame(4'(g), nw * 8, v);
  endtask

  // Host pacing and the hang limit
  always @(posedge clock) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    hready <= 16'($urandom) & hmask;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // Output watcher: takes the oldest note whenever a result appears
  always @(negedge clock) begin
    if (rd_d) begin
      chk("reg_rdata", reg_rdata & rdq_m.pop_front(), rdq_e.pop_front());
    end
    for (int g = 0; g < 16; g++) begin
      if (hvalid[g] && hready[g]) begin
        if (fq[g].size() == 0) chk("unexpected host word", 1, 0);
        else chk("host word", hdata[g], fq[g].pop_front());
      end
    end
    if (txv && txr) chk("ser_tx_data", txd, txq.pop_front());
  end

  initial begin
    void'($urandom(32'h8259));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(`IADTHC_OFF_NUM_GROUPS, 32'h0000_0010, '1);
    rd(`IADTHC_OFF_LINK_MODE, 32'h0000_0000, '1);
    rd(8'h30, 32'h0000_0000, '1);
    for (int g = 0; g < 16; g++) begin
      rd(8'(8'h40 + 4 * g), 32'h0100_0001, '1);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`IADTHC_OFF_LINK_MODE, m);
      rd(`IADTHC_OFF_LINK_MODE, (m > 2) ? 2 : m, '1);
      chk("cam_link_mode", lmode, (m > 2) ? 2 : m);
    end
    ce <= 1'b0; // Frozen core: this write must not land
    wr(`IADTHC_OFF_LINK_MODE, 32'h0000_0001);
    ce <= 1'b1;
    rd(`IADTHC_OFF_LINK_MODE, 32'h0000_0002, '1);
    wr(`IADTHC_OFF_CTRL, 32'h0000_0001);
    wr(`IADTHC_OFF_GROUP_ENABLE, 32'h0000_0001);
    b = 8'($urandom);
    send(0, 2, 2, b);
    send(3, 1, 0, b);
    fork // Enable raised in mid-frame must wait for the next frame
      cam.frame(4'h1, 16, b);
      begin
        repeat (4) @(posedge clock);
        wr(`IADTHC_OFF_GROUP_ENABLE, 32'h0000_0003);
      end
    join
    send(1, 1, 1, 8'(b + 5));
    hmask = 16'hFFFB; // Host stalls group 2
    wr(`IADTHC_OFF_GROUP_ENABLE, 32'h0000_0007);
    @(negedge clock);
    chk("irq masked", irq, 0);
    send(2, 17, 16, b);
    rd(`IADTHC_OFF_OVERFLOW, 32'h0000_0004, '1);
    wr(`IADTHC_OFF_IRQ_ENABLE, 32'h0000_0002);
    @(negedge clock);
    chk("irq raised", irq, 1);
    rd(`IADTHC_OFF_IRQ_STATUS, 32'h0000_0003, 32'h0000_0003);
    wr(`IADTHC_OFF_IRQ_CLEAR, 32'h0000_0002);
    @(negedge clock);
    chk("irq cleared", irq, 0);
    hmask = 16'hFFFF;
    repeat (60) @(posedge clock);
    rd(`IADTHC_OFF_OVERFLOW, 32'h0000_0004, '1);
    wr(`IADTHC_OFF_CTRL, 32'h0000_0000);
    wr(`IADTHC_OFF_CTRL, 32'h0000_0001);
    rd(`IADTHC_OFF_OVERFLOW, 32'h0000_0000, '1);
    for (int i = 0; i < 2; i++) begin
      slow <= 1'(i); // Prompt, then slow transmitter
      b = 8'($urandom);
      txq.push_back(b);
      wr(`IADTHC_OFF_SER_TX, b);
      repeat (20) @(posedge clock);
    end
    rd(`IADTHC_OFF_SER_TX, 32'h0000_0000, 32'h0000_0001);
    b = 8'($urandom);
    cam.rx(b);
    rd(`IADTHC_OFF_SER_RX, {23'h0, 1'b1, b}, 32'h0000_01FF);
    rd(`IADTHC_OFF_SER_RX, 32'h0000_0000, 32'h0000_0100);
    repeat (5) @(posedge clock);
    // Every expected word and byte must have shown up by now
    for (int g = 0; g < 16; g++) begin
      chk("host words left", fq[g].size(), 0);
    end
    chk("serial bytes left", txq.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
